//--- sbp_pkg.sv
// Package with register map, field layout and pin carriers for the six-bit port
package sbp_pkg;

    // ****************************************************************
    // Register map: register indexes, the byte address is four times the index
    // ****************************************************************
    localparam logic [15:0] SBP_OFF_PIN_DIRECTION  = 16'hfeb2;
    localparam logic [15:0] SBP_OFF_PIN_LEVEL_READ = 16'hff52;
    localparam logic [15:0] SBP_OFF_OUTPUT_LATCH   = 16'hff62;
    localparam logic [15:0] SBP_OFF_OPEN_DRAIN_SEL = 16'hff76;
    localparam logic [15:0] SBP_OFF_SERIAL_CTRL    = 16'hff80;
    localparam logic [15:0] SBP_OFF_STANDBY_CTRL   = 16'hff84;

    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int          SBP_PINS         = 6;
    localparam logic [5:0]  SBP_PORT_RST     = 6'h00;
    localparam logic [31:0] SBP_UNDEF_RD     = 32'h00000000;
    localparam logic [1:0]  SBP_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  SBP_RESP_SLVERR  = 2'h2;
    localparam int          SBP_PIN_CLK1     = 5;
    localparam int          SBP_PIN_CLK0     = 4;
    localparam int          SBP_PIN_RX1      = 3;
    localparam int          SBP_PIN_RX0      = 2;
    localparam int          SBP_PIN_TX1      = 1;
    localparam int          SBP_PIN_TX0      = 0;
    // Serial control register bits, channel 0 in [4:0], channel 1 in [12:8]
    localparam int          SBP_SC_CKE_LO    = 0;
    localparam int          SBP_SC_CKE_HI    = 1;
    localparam int          SBP_SC_SYNC      = 2;
    localparam int          SBP_SC_RE        = 3;
    localparam int          SBP_SC_TE        = 4;
    localparam int          SBP_SC_CH1       = 8;
    localparam logic [15:0] SBP_SC_MASK      = 16'h1f1f;
    localparam int          SBP_SB_SOFT      = 0;
    localparam int          SBP_SB_HARD      = 1;
    localparam logic [1:0]  SBP_SYNC_ONES    = 2'h3;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic clock_enable_low;
        logic clock_enable_high;
        logic sync_mode;
        logic receive_enable;
        logic transmit_enable;
    } sbp_serial_ctl_t;

    typedef struct packed {
        logic serial_clock;
        logic transmit;
    } sbp_serial_out_t;

    typedef struct packed {
        logic [5:0] o;
        logic [5:0] oe;
    } sbp_pin_drive_t;

endpackage : sbp_pkg

//--- sbp_port.sv
// Six-bit general-purpose port shared with two serial channels, AXI4-Lite slave
`timescale 1ns/1ns

// How it works
// - Six two-way pins 5..0; serial sharing is the same in every chip mode.
// - In general use a direction bit 1 drives the pin, 0 leaves it input.
// - Direction register is write-only; reads give undefined, bits 7 and 6 reserved.
// - Reset and hardware standby clear direction, latch and open-drain; software standby keeps.
// - Bits 7 and 6 of latch, level and open-drain read undefined, ignore writes.
// - Level read gives latch bit when direction is 1, live pin when 0.
// - Open-drain bit 1 removes pull-up drive; 0 gives push-pull output.
// - Open-drain applies to general output and serial clock output only.
// - Pin 5: clock input if clock-high; clock output if sync or clock-low; else general.
// - Pin 4 uses the same clock selection with channel 0 bits.
// - Pin 3 is channel 1 receive input while its receive enable is set.
// - Pin 2 is channel 0 receive input while its receive enable is set.
// - Pin 1 is channel 1 transmit output while its transmit enable is set.
// - Pin 0 is channel 0 transmit output while its transmit enable is set.
// - Released serial pins fall back to direction and latch control.
// - Level register follows pins after reset; holds during software standby.
module sbp_port
    import sbp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [17:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [17:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire sbp_serial_out_t   serial_out_ch0,
    input  wire sbp_serial_out_t   serial_out_ch1,
    output logic                   serial_clock_ch0,
    output logic                   serial_clock_ch1,
    output logic                   receive_pin_ch0,
    output logic                   receive_pin_ch1,
    input  wire logic [5:0]        pin_i,
    output logic [5:0]             pin_o,
    output logic [5:0]             pin_oe
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [5:0]        pin_direction_r;
    logic [5:0]        output_latch_r;
    logic [5:0]        open_drain_select_r;
    logic [15:0]       serial_ctrl_r;
    logic [1:0]        standby_r;
    logic [5:0]        level_r;
    logic [5:0]        sync1_r;
    logic [5:0]        sync2_r;
    logic [5:0]        sync3_r;
    logic [5:0]        pin_stable_r;
    logic [15:0]       awaddr_r;
    logic              aw_held_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              w_held_r;
    logic              do_write;
    logic              wr_hit;
    sbp_serial_ctl_t   ch0;
    sbp_serial_ctl_t   ch1;
    sbp_pin_drive_t    drive;
    logic [5:0]        gp_mask;
    logic [5:0]        level_nxt;

    assign ch0 = sbp_serial_ctl_t'({serial_ctrl_r[SBP_SC_CKE_LO], serial_ctrl_r[SBP_SC_CKE_HI],
                 serial_ctrl_r[SBP_SC_SYNC], serial_ctrl_r[SBP_SC_RE], serial_ctrl_r[SBP_SC_TE]});
    assign ch1 = sbp_serial_ctl_t'({serial_ctrl_r[SBP_SC_CH1 + SBP_SC_CKE_LO],
                 serial_ctrl_r[SBP_SC_CH1 + SBP_SC_CKE_HI],
                 serial_ctrl_r[SBP_SC_CH1 + SBP_SC_SYNC],
                 serial_ctrl_r[SBP_SC_CH1 + SBP_SC_RE],
                 serial_ctrl_r[SBP_SC_CH1 + SBP_SC_TE]});

    // ****************************************************************
    // Write channel
    // ****************************************************************
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
    assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 16'h0000;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr[17:2];
            end
            else if (do_write)
                aw_held_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            else if (do_write)
                w_held_r <= 1'b0;
        end
    end

    always_comb
    begin
        wr_hit = 1'b1;
        case (awaddr_r)
            SBP_OFF_PIN_DIRECTION,
            SBP_OFF_PIN_LEVEL_READ,
            SBP_OFF_OUTPUT_LATCH,
            SBP_OFF_OPEN_DRAIN_SEL,
            SBP_OFF_SERIAL_CTRL,
            SBP_OFF_STANDBY_CTRL: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SBP_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? SBP_RESP_OKAY : SBP_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ****************************************************************
    // Port registers
    // ****************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pin_direction_r     <= SBP_PORT_RST;
            output_latch_r      <= SBP_PORT_RST;
            open_drain_select_r <= SBP_PORT_RST;
            serial_ctrl_r       <= 16'h0000;
            standby_r           <= 2'h0;
        end
        else if (standby_r[SBP_SB_HARD] && !(do_write
                 && awaddr_r == SBP_OFF_STANDBY_CTRL && wstrb_r[0]))
        begin
            pin_direction_r     <= SBP_PORT_RST;
            output_latch_r      <= SBP_PORT_RST;
            open_drain_select_r <= SBP_PORT_RST;
        end
        else if (do_write)
        begin
            // Writes take effect at the edge that completes the bus write
            // Data in byte lane 0, serial control in lanes 0 and 1 without strobe check; bits 7 and 6 are dropped
            if (awaddr_r == SBP_OFF_PIN_DIRECTION && wstrb_r[0])
                pin_direction_r <= wdata_r[5:0];
            if (awaddr_r == SBP_OFF_OUTPUT_LATCH && wstrb_r[0])
                output_latch_r <= wdata_r[5:0];
            if (awaddr_r == SBP_OFF_OPEN_DRAIN_SEL && wstrb_r[0])
                open_drain_select_r <= wdata_r[5:0];
            if (awaddr_r == SBP_OFF_SERIAL_CTRL)
                serial_ctrl_r <= wdata_r[15:0] & SBP_SC_MASK;
            if (awaddr_r == SBP_OFF_STANDBY_CTRL && wstrb_r[0])
                standby_r <= wdata_r[1:0];
        end
    end

    // ****************************************************************
    // Pin input sampling and level register
    // ****************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_r      <= 6'h00;
            sync2_r      <= 6'h00;
            sync3_r      <= 6'h00;
            pin_stable_r <= 6'h00;
        end
        else
        begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            for (int i = 0; i < SBP_PINS; i++)
            begin
                if (sync2_r[i] == sync3_r[i])
                    pin_stable_r[i] <= sync3_r[i];
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < SBP_PINS; i++)
            level_nxt[i] = pin_direction_r[i] ? output_latch_r[i] : pin_stable_r[i];
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            level_r <= 6'h00;
        else if (!standby_r[SBP_SB_SOFT])
            level_r <= level_nxt;
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= SBP_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= SBP_RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            case (s_axi_araddr[17:2])
                SBP_OFF_PIN_DIRECTION:
                    s_axi_rdata <= SBP_UNDEF_RD;
                SBP_OFF_PIN_LEVEL_READ:
                    s_axi_rdata <= {26'h0, level_r};
                SBP_OFF_OUTPUT_LATCH:
                    s_axi_rdata <= {26'h0, output_latch_r};
                SBP_OFF_OPEN_DRAIN_SEL:
                    s_axi_rdata <= {26'h0, open_drain_select_r};
                SBP_OFF_SERIAL_CTRL:
                    s_axi_rdata <= {16'h0000, serial_ctrl_r};
                SBP_OFF_STANDBY_CTRL:
                    s_axi_rdata <= {30'h00000000, standby_r};
                default:
                    s_axi_rresp <= SBP_RESP_SLVERR;
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ****************************************************************
    // Pin function selection
    // ****************************************************************
    always_comb
    begin
        // General use on every pin unless a serial function claims it
        drive.o  = output_latch_r;
        drive.oe = pin_direction_r;
        gp_mask  = 6'h3f;
        // Clock pins, independent of chip mode
        if (ch1.clock_enable_high)
        begin
            drive.oe[SBP_PIN_CLK1] = 1'b0;
            gp_mask[SBP_PIN_CLK1]  = 1'b0;
        end
        else if (ch1.sync_mode || ch1.clock_enable_low)
        begin
            drive.o[SBP_PIN_CLK1]  = serial_out_ch1.serial_clock;
            drive.oe[SBP_PIN_CLK1] = 1'b1;
        end
        if (ch0.clock_enable_high)
        begin
            drive.oe[SBP_PIN_CLK0] = 1'b0;
            gp_mask[SBP_PIN_CLK0]  = 1'b0;
        end
        else if (ch0.sync_mode || ch0.clock_enable_low)
        begin
            drive.o[SBP_PIN_CLK0]  = serial_out_ch0.serial_clock;
            drive.oe[SBP_PIN_CLK0] = 1'b1;
        end
        if (ch1.receive_enable)
        begin
            drive.oe[SBP_PIN_RX1] = 1'b0;
            gp_mask[SBP_PIN_RX1]  = 1'b0;
        end
        if (ch0.receive_enable)
        begin
            drive.oe[SBP_PIN_RX0] = 1'b0;
            gp_mask[SBP_PIN_RX0]  = 1'b0;
        end
        if (ch1.transmit_enable)
        begin
            drive.o[SBP_PIN_TX1]  = serial_out_ch1.transmit;
            drive.oe[SBP_PIN_TX1] = 1'b1;
            gp_mask[SBP_PIN_TX1]  = 1'b0;
        end
        if (ch0.transmit_enable)
        begin
            drive.o[SBP_PIN_TX0]  = serial_out_ch0.transmit;
            drive.oe[SBP_PIN_TX0] = 1'b1;
            gp_mask[SBP_PIN_TX0]  = 1'b0;
        end
    end

    // Open drain: a high level is released, not driven
    always_comb
    begin
        for (int i = 0; i < SBP_PINS; i++)
        begin
            pin_o[i]  = drive.o[i];
            pin_oe[i] = drive.oe[i]
                        && !(gp_mask[i] && open_drain_select_r[i] && drive.o[i]);
        end
    end

    assign serial_clock_ch0 = pin_stable_r[SBP_PIN_CLK0];
    assign serial_clock_ch1 = pin_stable_r[SBP_PIN_CLK1];
    assign receive_pin_ch0  = pin_stable_r[SBP_PIN_RX0];
    assign receive_pin_ch1  = pin_stable_r[SBP_PIN_RX1];

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    dir_write_a: assert property (do_write && awaddr_r == SBP_OFF_PIN_DIRECTION
        && wstrb_r[0] && !standby_r[SBP_SB_HARD]
        |=> pin_direction_r == $past(wdata_r[5:0]))
        else $error("direction write not applied");
    hard_clear_a: assert property (standby_r[SBP_SB_HARD] && !do_write
        |=> pin_direction_r == 6'h00 && output_latch_r == 6'h00)
        else $error("hardware standby did not clear");
    level_hold_a: assert property (standby_r[SBP_SB_SOFT] |=> $stable(level_r))
        else $error("level changed in software standby");
    level_sel_a: assert property (!standby_r[SBP_SB_SOFT]
        |=> level_r == $past(level_nxt))
        else $error("level register wrong source");
    tx1_pin_a: assert property (ch1.transmit_enable
        |-> pin_oe[SBP_PIN_TX1] && pin_o[SBP_PIN_TX1] == serial_out_ch1.transmit)
        else $error("tx1 pin not driven");
    tx0_pin_a: assert property (ch0.transmit_enable
        |-> pin_oe[SBP_PIN_TX0] && pin_o[SBP_PIN_TX0] == serial_out_ch0.transmit)
        else $error("tx0 pin not driven");
    rx_pins_a: assert property (ch1.receive_enable || ch0.receive_enable
        |-> !(ch1.receive_enable && pin_oe[SBP_PIN_RX1])
            && !(ch0.receive_enable && pin_oe[SBP_PIN_RX0]))
        else $error("receive pin driven");
    clk_in_a: assert property (ch1.clock_enable_high |-> !pin_oe[SBP_PIN_CLK1])
        else $error("clock input pin driven");
    gp_dir_a: assert property (!ch0.clock_enable_high && !ch0.sync_mode
        && !ch0.clock_enable_low && !open_drain_select_r[SBP_PIN_CLK0]
        |-> pin_oe[SBP_PIN_CLK0] == pin_direction_r[SBP_PIN_CLK0])
        else $error("general pin direction wrong");
    od_high_a: assert property (gp_mask[1] && open_drain_select_r[1] && drive.o[1]
        |-> !pin_oe[1])
        else $error("open drain drove high");
    wr_resp_a: assert property (do_write |=> s_axi_bvalid)
        else $error("write response missing");

    cov_write_c: cover property (do_write ##1 s_axi_bvalid && s_axi_bready);
    cov_read_c: cover property (s_axi_rvalid && s_axi_rready);
    cov_tx_c: cover property (ch0.transmit_enable && ch1.transmit_enable);
    cov_clkout_c: cover property (ch1.sync_mode && pin_oe[SBP_PIN_CLK1]);

endmodule : sbp_port

//--- sbp_pins_model.sv
// Board model for the six port pins
`timescale 1ns/1ns

module sbp_pins_model
    import sbp_pkg::*;
(
    input  wire logic [5:0] pin_o,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] ext_en,
    input  wire logic [5:0] ext_v,
    output logic      [5:0] pin_i
);
    // ****
    // Wire level
    // ****
    always_comb
    begin
        for (int k = 0; k < SBP_PINS; k++)
        begin
            pin_i[k] = pin_oe[k] ? pin_o[k] : (ext_en[k] ? ext_v[k] : 1'b1);
        end
    end
endmodule : sbp_pins_model

//--- sbp_port_test.sv
// Self-checking bench for the six-bit port
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module sbp_port_test;
    import sbp_pkg::*;
    logic            clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic            s_axi_arvalid, s_axi_rready, s_axi_rvalid;
    logic [17:0]     s_axi_awaddr, s_axi_araddr;
    logic [15:0]     sc;
    logic [31:0]     s_axi_wdata, s_axi_rdata, d;
    logic [3:0]      s_axi_wstrb;
    logic [1:0]      s_axi_bresp, s_axi_rresp, rsp;
    sbp_serial_out_t serial_out_ch0, serial_out_ch1;
    logic            serial_clock_ch0, serial_clock_ch1, receive_pin_ch0, receive_pin_ch1;
    logic [5:0]      pin_i, pin_o, pin_oe, ext_en, ext_v, oe_b;
    logic [7:0]      dir, lat, od, b;
    logic [15:0]     sc_tab [4] = '{16'h0000, 16'h1f1f, 16'h1515, 16'h0c0c};
    int              failures, num_checks, seed, cyc;

    sbp_port sbp_port_inst (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_out_ch0,
        .serial_out_ch1, .serial_clock_ch0, .serial_clock_ch1, .receive_pin_ch0,
        .receive_pin_ch1, .pin_i, .pin_o, .pin_oe);
    sbp_pins_model sbp_pins_model_inst (.pin_o, .pin_oe, .ext_en, .ext_v, .pin_i);

    // ****
    // Bus tasks and expectations
    // ****
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s);
        bit aw, w;
        aw = 0; w = 0;
        s_axi_awaddr <= {a, 2'b00}; s_axi_wdata <= v; s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (aw && w && s_axi_bvalid === 1'b1) break;
            if (s_axi_awready === 1'b1) aw = 1'b1;
            if (s_axi_wready === 1'b1) w = 1'b1;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        rsp = s_axi_bresp;
        oe_b = pin_oe;
    endtask : axi_wr

    task automatic axi_rd(input logic [15:0] a, output logic [31:0] v);
        bit ar;
        ar = 0;
        s_axi_araddr <= {a, 2'b00}; s_axi_arvalid <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (ar && s_axi_rvalid === 1'b1) break;
            if (s_axi_arready === 1'b1) ar = 1'b1;
            if (ar) s_axi_arvalid <= 1'b0;
        end
        v = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : axi_rd

    task automatic wb(input logic [15:0] off, input logic [7:0] v);
        axi_wr(off, {24'h000000, v}, 4'h1);
    endtask : wb

    task automatic rb(input logic [15:0] off, output logic [7:0] v);
        logic [31:0] t;
        axi_rd(off, t);
        v = t[7:0];
    endtask : rb

    function automatic logic [11:0] exp_drv(input logic [5:0] dr, lt, odr,
        input logic [15:0] ctl, input sbp_serial_out_t s0, s1);
        logic [5:0] v, e, c;
        logic [4:0] bt;
        logic       ck;
        v = lt; e = dr; c = 6'h3f;
        for (int ch = 0; ch < 2; ch++)
        begin
            bt = ctl[ch*8 +: 5];
            ck = !bt[1] && (bt[2] || bt[0]);
            if (bt[1] || ck) e[4+ch] = ck;
            if (ck) v[4+ch] = ch ? s1.serial_clock : s0.serial_clock;
            if (bt[3]) e[2+ch] = 1'b0;
            if (bt[4]) e[ch] = 1'b1;
            if (bt[4]) v[ch] = ch ? s1.transmit : s0.transmit;
            if (bt[4]) c[ch] = 1'b0;
        end
        return {v, e & ~(odr & c & v)};
    endfunction : exp_drv

    task automatic chk_all;
        logic [11:0] x;
        logic [5:0]  e, w;
        x = exp_drv(dir[5:0], lat[5:0], od[5:0], sc, serial_out_ch0, serial_out_ch1);
        e = x[5:0];
        w = (e & x[11:6]) | (~e & ((ext_en & ext_v) | ~ext_en));
        `CHK("pin_oe", e, pin_oe)
        `CHK("pin_o", x[11:6] & e, pin_o & pin_oe)
        `CHK("oe_at_resp", e, oe_b)
        `CHK("sck", {w[5], w[4]}, {serial_clock_ch1, serial_clock_ch0})
        `CHK("rxd", {w[3], w[2]}, {receive_pin_ch1, receive_pin_ch0})
        rb(SBP_OFF_PIN_LEVEL_READ, b);
        `CHK("level", {2'b00, (dir[5:0] & lat[5:0]) | (~dir[5:0] & w)}, b)
        rb(SBP_OFF_OUTPUT_LATCH, b);
        `CHK("latch", {2'b00, lat[5:0]}, b)
        rb(SBP_OFF_OPEN_DRAIN_SEL, b);
        `CHK("odr", {2'b00, od[5:0]}, b)
        rb(SBP_OFF_PIN_DIRECTION, b);
        `CHK("dir", 8'h00, b)
    endtask : chk_all

    task automatic report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    // ****
    // Clock, timeout and sequence
    // ****
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            report_and_stop;
        end
    end

    initial
    begin
        reset = 1'b1; s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_arvalid = 0;
        s_axi_bready = 1'b1; s_axi_rready = 1'b1; s_axi_awaddr = 0; s_axi_araddr = 0;
        s_axi_wdata = 0; s_axi_wstrb = 0; serial_out_ch0 = 0; serial_out_ch1 = 0;
        ext_en = 0; ext_v = 0; oe_b = 0; dir = 0; lat = 0; od = 0; sc = 0;
        failures = 0; num_checks = 0; cyc = 0; seed = 26986;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        chk_all;
        $display("test reset done");
        for (int i = 0; i < 40; i++)
        begin
            dir = $random(seed); lat = $random(seed); od = $random(seed);
            sc = $random(seed) & SBP_SC_MASK;
            if (i < 4) sc = sc_tab[i];
            if (i < 2) dir = 8'hff;
            serial_out_ch0 <= $random(seed); serial_out_ch1 <= $random(seed);
            ext_en <= $random(seed); ext_v <= $random(seed);
            wb(SBP_OFF_PIN_DIRECTION, dir);
            `CHK("wr_resp", SBP_RESP_OKAY, rsp)
            wb(SBP_OFF_OUTPUT_LATCH, lat);
            wb(SBP_OFF_OPEN_DRAIN_SEL, od);
            axi_wr(SBP_OFF_SERIAL_CTRL, {16'h0000, sc}, 4'h3);
            repeat (8) @(posedge clk);
            chk_all;
        end
        $display("test random done");
        axi_wr(16'h1000, 32'hffffffff, 4'hf);
        `CHK("unmapped_wr", SBP_RESP_SLVERR, rsp)
        axi_rd(16'h1000, d);
        `CHK("unmapped_rd", {SBP_RESP_SLVERR, 32'h0}, {rsp, d})
        $display("test unmapped done");
        ext_en <= 6'h3f; ext_v <= 6'h15;
        wb(SBP_OFF_PIN_DIRECTION, 8'h00); wb(SBP_OFF_OUTPUT_LATCH, 8'h3f);
        axi_wr(SBP_OFF_SERIAL_CTRL, 32'h0, 4'h3);
        repeat (8) @(posedge clk);
        axi_wr(SBP_OFF_STANDBY_CTRL, 32'h1, 4'h1);
        ext_v <= 6'h2a;
        repeat (8) @(posedge clk);
        rb(SBP_OFF_PIN_LEVEL_READ, b);
        `CHK("soft_level", 8'h15, b)
        rb(SBP_OFF_OUTPUT_LATCH, b);
        `CHK("soft_latch", 8'h3f, b)
        axi_wr(SBP_OFF_STANDBY_CTRL, 32'h0, 4'h1);
        repeat (8) @(posedge clk);
        rb(SBP_OFF_PIN_LEVEL_READ, b);
        `CHK("woke_level", 8'h2a, b)
        $display("test soft standby done");
        wb(SBP_OFF_PIN_DIRECTION, 8'h3f); wb(SBP_OFF_OPEN_DRAIN_SEL, 8'h01);
        axi_wr(SBP_OFF_STANDBY_CTRL, 32'h2, 4'h1);
        rb(SBP_OFF_OUTPUT_LATCH, b);
        `CHK("hard_latch", 8'h00, b)
        rb(SBP_OFF_OPEN_DRAIN_SEL, b);
        `CHK("hard_odr", 8'h00, b)
        `CHK("hard_oe", 6'h00, pin_oe)
        axi_wr(SBP_OFF_STANDBY_CTRL, 32'h0, 4'h1);
        $display("test hard standby done");
        report_and_stop;
    end
endmodule : sbp_port_test
